//--- logic/ctp_timer_bank.sv
// four cascadable 16-bit timer pairs with register port and trigger outputs
//
// Behaviour
// - pair runs as two 16-bit or one 32-bit
// - split halves support all synchronous 16-bit modes
// - joined pair: 32-bit timer or synchronous counter
// - every 16-bit timer times or counts synchronously
// - even timer low word, odd high word
// - joined pair ignores odd timer control bits
// - even clock and gate, odd interrupt flag
// - cascade-select bit joins the pair
// - two-bit prescale select; even field when joined
// - clock-source bit and gate-enable bit
// - 32-bit period from odd:even period registers
// - count readable as odd:even register pair
// - period match raises enabled, prioritised interrupt
// - timers keep running in sleep, and in idle unless the stop-in-idle bit is set
// - only pair zero feeds capture/compare time base
// - pair zero triggers ADC one, pair one ADC two
// - only pair zero timers request DMA
`timescale 1ns/1ps
module ctp_timer_bank (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // register port
   input wire logic [ctp_pkg::AW-1:0] reg_addr,
   input wire logic [ctp_pkg::DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [ctp_pkg::DW-1:0] reg_rdata,
   // timer clock / gate pins, one per timer
   input wire logic [ctp_pkg::NT-1:0] tmr_pin,
   // power state
   input wire logic idle_mode,
   // interrupt requests toward the interrupt controller
   output logic [ctp_pkg::NT-1:0] irq_req,
   output logic [ctp_pkg::NT-1:0][2:0] irq_priority,
   // capture/compare time base from pair zero
   output logic [ctp_pkg::DW-1:0] tb_count_lo,
   output logic [ctp_pkg::DW-1:0] tb_count_hi,
   // event triggers
   output logic adc1_trig,
   output logic adc2_trig,
   output logic [1:0] dma_req
);

   // ************************************************************
   // register storage
   // ************************************************************
   logic [15:0] ctrl_q [ctp_pkg::NT];
   logic [15:0] per_q [ctp_pkg::NT];
   logic [15:0] cnt_q [ctp_pkg::NT];
   logic [ctp_pkg::NT-1:0] flag_q;
   logic [ctp_pkg::NT-1:0] ien_q;
   logic [2:0] ipri_q [ctp_pkg::NT];
   logic [15:0] rdata_q;
   logic adc1_q;
   logic adc2_q;
   logic [1:0] dma_q;

   // ************************************************************
   // next-state nets, one driver per element
   // ************************************************************
   wire [15:0] ctrl_d [ctp_pkg::NT];
   wire [15:0] per_d [ctp_pkg::NT];
   wire [15:0] cnt_d [ctp_pkg::NT];
   wire [ctp_pkg::NT-1:0] flag_d;
   wire [ctp_pkg::NT-1:0] ien_d;
   wire [2:0] ipri_d [ctp_pkg::NT];
   wire [ctp_pkg::NT-1:0] set_flag;

   // ************************************************************
   // address decode
   // ************************************************************
   wire [2:0] sel_tmr;
   wire [1:0] sel_reg;
   wire [ctp_pkg::NT-1:0] wr_ctrl;
   wire [ctp_pkg::NT-1:0] wr_per;
   wire [ctp_pkg::NT-1:0] wr_cnt;
   wire [ctp_pkg::NT-1:0] wr_irq;

   assign sel_tmr = reg_addr[4:2];
   assign sel_reg = reg_addr[1:0];

   // ************************************************************
   // pin synchroniser
   // ************************************************************
   wire [ctp_pkg::NT-1:0] pin_lvl;
   wire [ctp_pkg::NT-1:0] pin_rise;
   wire [ctp_pkg::NT-1:0] pin_fall;

   ctp_pin_sync #(
      .W(ctp_pkg::NT)
   ) u_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .pin_async(tmr_pin),
      .level(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // ************************************************************
   // per-timer configuration, prescaler and register writes
   // ************************************************************
   wire [ctp_pkg::NT-1:0] run;
   wire [ctp_pkg::NT-1:0] cfg_cs;
   wire [ctp_pkg::NT-1:0] cfg_gate;
   wire [ctp_pkg::NT-1:0] gate_fall;
   wire [ctp_pkg::NT-1:0] tick;
   wire [ctp_pkg::NT-1:0] casc_of;

   genvar gt;
   generate
      for (gt = 0; gt < ctp_pkg::NT; gt++) begin : g_tmr
         localparam logic [2:0] IDX = 3'(gt);
         localparam bit IS_ODD = (gt % 2) == 1;
         ctp_presc_if pif ();
         wire [15:0] cfg;
         wire sel;

         // a joined pair sets its odd half up from the even control word
         assign casc_of[gt] = ctrl_q[gt - (gt % 2)][ctp_pkg::CTRL_CASCADE];
         assign cfg = (IS_ODD && casc_of[gt]) ? ctrl_q[gt - 1] : ctrl_q[gt];
         assign cfg_cs[gt] = cfg[ctp_pkg::CTRL_CS];
         assign cfg_gate[gt] = cfg[ctp_pkg::CTRL_GATE] & ~cfg[ctp_pkg::CTRL_CS];

         // idle halts only when asked to; sleep has no effect at all
         assign run[gt] = cfg[ctp_pkg::CTRL_ON] &
                          ~(idle_mode & cfg[ctp_pkg::CTRL_STOP_IDLE]);

         // external rising edges count, a high gate admits internal clocks
         assign pif.src_en = run[gt] & (cfg_cs[gt] ? pin_rise[gt] :
                             (cfg_gate[gt] ? pin_lvl[gt] : 1'b1));
         assign pif.clr = ~run[gt] | (IS_ODD && casc_of[gt]);
         assign pif.ratio = cfg[ctp_pkg::CTRL_PS_LO +: 2];
         assign tick[gt] = pif.tick;
         assign gate_fall[gt] = run[gt] & cfg_gate[gt] & pin_fall[gt];

         ctp_prescaler u_presc (
            .clk_sys(clk_sys),
            .srst(srst),
            .pif(pif)
         );

         assign sel = sel_tmr == IDX;
         assign wr_ctrl[gt] = reg_wr & sel & (sel_reg == ctp_pkg::REG_CTRL);
         assign wr_per[gt] = reg_wr & sel & (sel_reg == ctp_pkg::REG_PERIOD);
         assign wr_cnt[gt] = reg_wr & sel & (sel_reg == ctp_pkg::REG_COUNT);
         assign wr_irq[gt] = reg_wr & sel & (sel_reg == ctp_pkg::REG_IRQ);

         // the cascade bit lives only in even control words
         assign ctrl_d[gt] = wr_ctrl[gt] ?
                             (reg_wdata & (IS_ODD ? ctp_pkg::CTRL_MASK_ODD :
                                                    ctp_pkg::CTRL_MASK_EVEN)) :
                             ctrl_q[gt];
         assign per_d[gt] = wr_per[gt] ? reg_wdata : per_q[gt];
         assign ien_d[gt] = wr_irq[gt] ? reg_wdata[ctp_pkg::IRQ_EN] : ien_q[gt];
         assign ipri_d[gt] = wr_irq[gt] ? reg_wdata[ctp_pkg::IRQ_PRI_LO +: 3] :
                             ipri_q[gt];

         // a hardware set in the same cycle as a software clear wins
         assign flag_d[gt] = set_flag[gt] |
                             (wr_irq[gt] ? reg_wdata[ctp_pkg::IRQ_FLAG] : flag_q[gt]);
      end
   endgenerate

   // ************************************************************
   // per-pair counting
   // ************************************************************
   genvar gp;
   generate
      for (gp = 0; gp < ctp_pkg::NP; gp++) begin : g_pair
         localparam int unsigned E = 2 * gp;
         localparam int unsigned O = 2 * gp + 1;
         wire casc;
         wire [31:0] c32;
         wire [31:0] p32;
         wire [31:0] n32;
         wire hit32;
         wire hit_e;
         wire hit_o;
         wire [15:0] n_e;
         wire [15:0] n_o;
         wire ev_pair;
         wire ev_e;
         wire ev_o;

         assign casc = ctrl_q[E][ctp_pkg::CTRL_CASCADE];
         assign c32 = {cnt_q[O], cnt_q[E]};
         assign p32 = {per_q[O], per_q[E]};
         assign hit32 = c32 == p32;
         assign hit_e = cnt_q[E] == per_q[E];
         assign hit_o = cnt_q[O] == per_q[O];

         // the count sits on the period for one tick, then wraps to zero
         assign n32 = hit32 ? 32'h0000_0000 : 32'(c32 + 32'h0000_0001);
         assign n_e = hit_e ? 16'h0000 : 16'(cnt_q[E] + 16'h0001);
         assign n_o = hit_o ? 16'h0000 : 16'(cnt_q[O] + 16'h0001);

         // joined pair ticks on the even prescaler only
         assign cnt_d[E] = wr_cnt[E] ? reg_wdata :
                           ~tick[E] ? cnt_q[E] :
                           casc ? n32[15:0] : n_e;
         assign cnt_d[O] = wr_cnt[O] ? reg_wdata :
                           casc ? (tick[E] ? n32[31:16] : cnt_q[O]) :
                           (tick[O] ? n_o : cnt_q[O]);

         // gated timers flag the gate fall instead of the period match
         assign ev_pair = cfg_gate[E] ? gate_fall[E] : (tick[E] & hit32);
         assign ev_e = cfg_gate[E] ? gate_fall[E] : (tick[E] & hit_e);
         assign ev_o = cfg_gate[O] ? gate_fall[O] : (tick[O] & hit_o);

         // joined pair reports through the odd timer's flag
         assign set_flag[E] = ~casc & ev_e;
         assign set_flag[O] = casc ? ev_pair : ev_o;
      end
   endgenerate

   // ************************************************************
   // register file update
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int i = 0; i < ctp_pkg::NT; i++) begin
            ctrl_q[i] <= ctp_pkg::CTRL_RESET;
            per_q[i] <= ctp_pkg::PERIOD_RESET;
            cnt_q[i] <= ctp_pkg::COUNT_RESET;
            ipri_q[i] <= 3'h0;
         end
         flag_q <= '0;
         ien_q <= '0;
      end else begin
         for (int i = 0; i < ctp_pkg::NT; i++) begin
            ctrl_q[i] <= ctrl_d[i];
            per_q[i] <= per_d[i];
            cnt_q[i] <= cnt_d[i];
            ipri_q[i] <= ipri_d[i];
         end
         flag_q <= flag_d;
         ien_q <= ien_d;
      end
   end

   // ************************************************************
   // read path: data stand only in the cycle after the strobe
   // ************************************************************
   wire [15:0] rd_irq;
   wire [15:0] rd_word;

   assign rd_irq = {11'h000, ipri_q[sel_tmr], ien_q[sel_tmr], flag_q[sel_tmr]};
   assign rd_word = (sel_reg == ctp_pkg::REG_CTRL) ? ctrl_q[sel_tmr] :
                    (sel_reg == ctp_pkg::REG_PERIOD) ? per_q[sel_tmr] :
                    (sel_reg == ctp_pkg::REG_COUNT) ? cnt_q[sel_tmr] : rd_irq;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= reg_rd ? rd_word : 16'h0000;
      end
   end

   assign reg_rdata = rdata_q;

   // ************************************************************
   // interrupt requests
   // ************************************************************
   // the request follows the flag so that software sees it until it clears
   assign irq_req = flag_q & ien_q;

   genvar gi;
   generate
      for (gi = 0; gi < ctp_pkg::NT; gi++) begin : g_pri
         assign irq_priority[gi] = ipri_q[gi];
      end
   endgenerate

   // ************************************************************
   // trigger outputs
   // ************************************************************
   // triggers are registered one-cycle pulses of the timers' flag-setting events
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         adc1_q <= 1'b0;
         adc2_q <= 1'b0;
         dma_q <= 2'b00;
      end else begin
         adc1_q <= set_flag[1];
         adc2_q <= set_flag[3];
         dma_q <= set_flag[1:0];
      end
   end

   assign adc1_trig = adc1_q;
   assign adc2_trig = adc2_q;
   assign dma_req = dma_q;

   // only pair zero drives the capture/compare time base
   assign tb_count_lo = cnt_q[0];
   assign tb_count_hi = cnt_q[1];

endmodule

//--- logic/ctp_pkg.sv
// constants shared by the cascadable timer pair bank
package ctp_pkg;

   // ************************************************************
   // sizes
   // ************************************************************
   localparam int unsigned DW = 16;
   localparam int unsigned NT = 8;
   localparam int unsigned NP = 4;
   localparam int unsigned AW = 5;

   // ************************************************************
   // register map: addr[4:2] selects the timer, addr[1:0] the register
   // ************************************************************
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_PERIOD = 2'h1;
   localparam logic [1:0] REG_COUNT = 2'h2;
   localparam logic [1:0] REG_IRQ = 2'h3;

   // ************************************************************
   // control register fields
   // ************************************************************
   localparam int unsigned CTRL_ON = 15;
   localparam int unsigned CTRL_STOP_IDLE = 13;
   localparam int unsigned CTRL_GATE = 6;
   localparam int unsigned CTRL_PS_LO = 4;
   localparam int unsigned CTRL_CASCADE = 3;
   localparam int unsigned CTRL_CS = 1;
   localparam logic [15:0] CTRL_MASK_EVEN = 16'ha07a;
   localparam logic [15:0] CTRL_MASK_ODD = 16'ha072;
   localparam logic [15:0] CTRL_RESET = 16'h0000;

   // ************************************************************
   // interrupt register fields
   // ************************************************************
   localparam int unsigned IRQ_FLAG = 0;
   localparam int unsigned IRQ_EN = 1;
   localparam int unsigned IRQ_PRI_LO = 2;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [15:0] PERIOD_RESET = 16'hffff;
   localparam logic [15:0] COUNT_RESET = 16'h0000;

   // ************************************************************
   // prescaler terminal counts for ratios 1, 8, 64, 256
   // ************************************************************
   localparam logic [7:0] PS_TERM_1 = 8'h00;
   localparam logic [7:0] PS_TERM_8 = 8'h07;
   localparam logic [7:0] PS_TERM_64 = 8'h3f;
   localparam logic [7:0] PS_TERM_256 = 8'hff;

endpackage

//--- logic/ctp_presc_if.sv
// carrier between the timer bank and one prescaler
`timescale 1ns/1ps
interface ctp_presc_if;
   logic src_en;
   logic clr;
   logic [1:0] ratio;
   logic tick;

   modport core (
      input src_en,
      input clr,
      input ratio,
      output tick
   );
   modport ctrl (
      output src_en,
      output clr,
      output ratio,
      input tick
   );
endinterface

//--- logic/ctp_pin_sync.sv
// two-flop synchroniser with edge detection for timer pins
`timescale 1ns/1ps
module ctp_pin_sync #(
   parameter int unsigned W = ctp_pkg::NT
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // asynchronous pins
   input wire logic [W-1:0] pin_async,
   // synchronised view
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // the first stage feeds only the second stage
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign level = s2_q;
   assign rise = s2_q & ~s3_q;
   assign fall = ~s2_q & s3_q;
endmodule

//--- logic/ctp_prescaler.sv
// clock-enable prescaler dividing a source enable by 1, 8, 64 or 256
`timescale 1ns/1ps
module ctp_prescaler (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // control and tick
   ctp_presc_if.core pif
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [7:0] term;

   assign term = (pif.ratio == 2'h0) ? ctp_pkg::PS_TERM_1 :
                 (pif.ratio == 2'h1) ? ctp_pkg::PS_TERM_8 :
                 (pif.ratio == 2'h2) ? ctp_pkg::PS_TERM_64 : ctp_pkg::PS_TERM_256;

   assign pif.tick = pif.src_en & ~pif.clr & (cnt_q == term);

   assign cnt_d = pif.clr ? 8'h00 :
                  pif.tick ? 8'h00 :
                  pif.src_en ? 8'(cnt_q + 8'h01) : cnt_q;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule

//--- bench/ctp_timer_bank_asserts.sv
// port-level assertions for the cascadable timer bank
`timescale 1ns/1ps
module ctp_timer_bank_asserts (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // register port
   input wire logic [ctp_pkg::AW-1:0] reg_addr,
   input wire logic [ctp_pkg::DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ctp_pkg::DW-1:0] reg_rdata,
   // observed outputs
   input wire logic [ctp_pkg::NT-1:0] irq_req,
   input wire logic [ctp_pkg::NT-1:0][2:0] irq_priority,
   input wire logic [ctp_pkg::DW-1:0] tb_count_lo,
   input wire logic [ctp_pkg::DW-1:0] tb_count_hi,
   input wire logic adc1_trig,
   input wire logic [1:0] dma_req
);
   // ************************************************************
   // shadow of timer 0 control
   // ************************************************************
   // gate and cascade change what a wrap of the low word means
   logic [15:0] ctl0_q;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctl0_q <= 16'h0000;
      end else if (reg_wr && reg_addr == 5'h00) begin
         ctl0_q <= reg_wdata;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   sequence s_wrap0;
      !$past(reg_wr) && $past(tb_count_lo) != 16'h0000 && tb_count_lo == 16'h0000;
   endsequence
   // ************************************************************
   // properties
   // ************************************************************
   chk_rdata_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside slot");
   chk_reset_clear: assert property (
      $past(srst) |-> irq_req == 8'h00 && tb_count_lo == 16'h0000)
      else $error("outputs not cleared by reset");
   chk_lo_step: assert property (
      !$past(reg_wr) && $changed(tb_count_lo)
      |-> tb_count_lo == $past(tb_count_lo) + 16'h0001 || tb_count_lo == 16'h0000)
      else $error("low count jumped");
   chk_hi_carry: assert property (
      ctl0_q[3] && !$past(reg_wr) && $changed(tb_count_hi) |-> tb_count_lo == 16'h0000)
      else $error("high word moved without low wrap");
   chk_even_flag: assert property (
      ctl0_q[3] && !$past(reg_wr) |-> !$rose(irq_req[0])) else $error("even flag in pair");
   chk_dma_wrap: assert property (
      s_wrap0 ##0 (!ctl0_q[6] && !ctl0_q[3]) |-> ##[0:1] dma_req[0])
      else $error("no dma request on match");
   chk_adc1_flag: assert property (
      $rose(irq_req[1]) && !$past(reg_wr) |-> ##[0:1] adc1_trig)
      else $error("no adc trigger on pair event");
   chk_prio_update: assert property (
      $past(reg_wr) && $past(reg_addr) == 5'h03
      |-> irq_priority[0] == $past(reg_wdata[4:2])) else $error("priority not taken");
   chk_count_hold: assert property (
      !ctl0_q[15] && !$past(ctl0_q[15]) && !$past(ctl0_q[15], 2) && !$past(reg_wr)
      |-> $stable(tb_count_lo)) else $error("stopped timer counted");
endmodule

bind ctp_timer_bank ctp_timer_bank_asserts u_chk (
   .clk_sys(clk_sys),
   .srst(srst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .irq_req(irq_req),
   .irq_priority(irq_priority),
   .tb_count_lo(tb_count_lo),
   .tb_count_hi(tb_count_hi),
   .adc1_trig(adc1_trig),
   .dma_req(dma_req)
);

//--- bench/tb.sv
// self-checking bench for the cascadable timer bank
`timescale 1ns/1ps
module tb;
   // ************************************************************
   // signals
   // ************************************************************
   typedef struct packed {
      logic w;
      logic [4:0] a;
      logic [15:0] d;
      logic [15:0] e;
   } ctp_row_t;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic [4:0] reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] tmr_pin = 8'h00;
   logic idle_mode = 1'b0;
   logic [15:0] reg_rdata, tb_count_lo, tb_count_hi, rd_v;
   logic [7:0] irq_req;
   logic [7:0][2:0] irq_priority;
   logic adc1_trig, adc2_trig;
   logic [1:0] dma_req;
   int fails = 0;
   int tests_run = 0;
   int adc1_n = 0, adc2_n = 0, dma_n = 0, n, m, k, g;
   int ratio [4] = '{1, 8, 64, 256};
   ctp_row_t rows [11] = '{
      '{1'b0, 5'h00, 16'h0000, 16'h0000}, '{1'b0, 5'h01, 16'h0000, 16'hffff},
      '{1'b0, 5'h02, 16'h0000, 16'h0000}, '{1'b0, 5'h03, 16'h0000, 16'h0000},
      '{1'b0, 5'h1c, 16'h0000, 16'h0000}, '{1'b1, 5'h18, 16'h7fff, 16'h207a},
      '{1'b1, 5'h1c, 16'h7fff, 16'h2072}, '{1'b1, 5'h15, 16'h1234, 16'h1234},
      '{1'b1, 5'h13, 16'hffff, 16'h001f}, '{1'b1, 5'h13, 16'h0000, 16'h0000},
      '{1'b1, 5'h0a, 16'habcd, 16'habcd}};

   ctp_timer_bank uut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tmr_pin(tmr_pin), .idle_mode(idle_mode), .irq_req(irq_req),
      .irq_priority(irq_priority), .tb_count_lo(tb_count_lo), .tb_count_hi(tb_count_hi),
      .adc1_trig(adc1_trig), .adc2_trig(adc2_trig), .dma_req(dma_req));

   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (adc1_trig === 1'b1) adc1_n++;
      if (adc2_trig === 1'b1) adc2_n++;
      if (dma_req !== 2'h0) dma_n++;
   end
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   // cycles from one low-word wrap to the next, bounded
   task automatic lo_wrap(output int c);
      c = 0;
      while (tb_count_lo === 16'h0000 && c < 2000) begin
         @(posedge clk_sys);
         #1 c++;
      end
      while (tb_count_lo !== 16'h0000 && c < 2000) begin
         @(posedge clk_sys);
         #1 c++;
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      fails++;
      end_of_test();
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rd_v);
         chk($sformatf("row %0d", i), rows[i].e, rd_v);
      end
      // prescaler ratios on timer 0 with period 1
      wr(5'h03, 16'h0016);
      wr(5'h01, 16'h0001);
      for (int p = 0; p < 4; p++) begin
         wr(5'h00, 16'h0000);
         wr(5'h02, 16'h0000);
         wr(5'h00, 16'h8000 | (16'(p) << 4));
         lo_wrap(g);
         lo_wrap(g);
         chk("prescale gap", 16'(2 * ratio[p]), 16'(g));
      end
      chk("irq0", 16'h0001, {15'h0, irq_req[0]});
      chk("pri0", 16'h0005, {13'h0, irq_priority[0]});
      chk("dma0", 16'h0001, {15'h0, dma_n > 0});
      // joined pair 0; odd control set to something it must ignore
      wr(5'h00, 16'h0008);
      wr(5'h03, 16'h0002);
      wr(5'h07, 16'h0002);
      wr(5'h02, 16'hfffe);
      wr(5'h06, 16'h0000);
      wr(5'h05, 16'h0001);
      wr(5'h04, 16'h8030);
      n = adc1_n;
      wr(5'h00, 16'h8008);
      for (k = 0; k < 20 && tb_count_hi !== 16'h0001; k++) @(posedge clk_sys) #1;
      chk("carry lo", 16'h0000, tb_count_lo);
      chk("carry hi", 16'h0001, tb_count_hi);
      for (k = 0; k < 20 && irq_req[1] !== 1'b1; k++) @(posedge clk_sys) #1;
      chk("match hi", 16'h0000, tb_count_hi);
      chk("match lo", 16'h0000, tb_count_lo);
      chk("even irq", 16'h0000, {15'h0, irq_req[0]});
      repeat (2) @(posedge clk_sys);
      chk("adc1 pair", 16'h0001, 16'(adc1_n - n));
      wr(5'h00, 16'h0000);
      // external clock on split timer 3, period 4, six edges
      n = adc1_n;
      m = adc2_n;
      k = dma_n;
      wr(5'h0d, 16'h0004);
      wr(5'h0c, 16'h8002);
      repeat (6) begin
         @(posedge clk_sys);
         tmr_pin[3] <= 1'b1;
         repeat (4) @(posedge clk_sys);
         tmr_pin[3] <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
      rd(5'h0e, rd_v);
      chk("ext count", 16'h0001, rd_v);
      chk("adc2", 16'h0001, 16'(adc2_n - m));
      chk("adc1 quiet", 16'h0000, 16'(adc1_n - n));
      chk("dma quiet", 16'h0000, 16'(dma_n - k));
      // gated accumulation on timer 2 for ten cycles
      wr(5'h0a, 16'h0000);
      wr(5'h08, 16'h8040);
      @(posedge clk_sys);
      tmr_pin[2] <= 1'b1;
      repeat (10) @(posedge clk_sys);
      tmr_pin[2] <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rd(5'h0a, rd_v);
      chk("gate count", 16'h000a, rd_v);
      rd(5'h0b, rd_v);
      chk("gate flag", 16'h0001, rd_v);
      chk("irq2 masked", 16'h0000, {15'h0, irq_req[2]});
      // joined pair 3 counting edges of the even pin; odd control stays ignored
      wr(5'h1a, 16'hffff);
      wr(5'h18, 16'h800a);
      repeat (2) begin
         @(posedge clk_sys);
         tmr_pin[6] <= 1'b1;
         repeat (4) @(posedge clk_sys);
         tmr_pin[6] <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
      rd(5'h1e, rd_v);
      chk("ext32 hi", 16'h0001, rd_v);
      rd(5'h1a, rd_v);
      chk("ext32 lo", 16'h0001, rd_v);
      // idle: held with stop_in_idle, running without it
      @(posedge clk_sys);
      idle_mode <= 1'b1;
      wr(5'h10, 16'ha000);
      repeat (8) @(posedge clk_sys);
      rd(5'h12, rd_v);
      chk("idle hold", 16'h0000, rd_v);
      wr(5'h10, 16'h8000);
      repeat (8) @(posedge clk_sys);
      rd(5'h12, rd_v);
      chk("idle run", 16'h0001, {15'h0, rd_v != 16'h0000});
      // second reset in mid-run
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      rd(5'h01, rd_v);
      chk("period after reset", 16'hffff, rd_v);
      chk("irq after reset", 16'h0000, {8'h0, irq_req});
      end_of_test();
   end
endmodule
